// ===== common/pisr_pkg.sv
// What this block does
// - package request follows the shallowest idle state requested by any compute core
// - enter C6 only with all cores C6+, graphics down, tolerance allowing C6
// - in C6 keep C3 conditions, stop base clock, request reduced regulator state
// - enter C8 only with all cores C8+, graphics down, tolerance allowing C8
// - C8 or C10 qualified and not demoted: flush last-level cache gradually or in one step, then remove its supply
// - enter C10 only with all cores C10, graphics down, tolerance allowing C10
// - C10 keeps C8 conditions, display self refresh or off, deepest regulator state, crystal off
// - display counts as self refreshing only with one embedded panel supporting it
// - a qualifying deep state may be demoted to a shallower one for performance
// - demotion weighs wake rate against its threshold and whether entry energy is paid back
// - auto-demotion enabled out of reset, switchable by firmware setting
// - cache flush gradual by ways or all at once, chosen by idle wait hint
// - on return to C0 the cache is re-enabled gradually
// - single display: at most C10 with self refresh, at most C8 without
// - memory not reserved for graphics goes to self refresh in C3 or deeper
package pisr_pkg;
    localparam int NUM_CORES = 4;
    localparam int LLC_WAYS = 8;
    localparam int WAY_W = 4;
    localparam int LAT_W = 16;
    localparam int WAKE_W = 8;
    // idle state codes, numbered so that deeper means larger
    typedef enum logic [2:0] {
        PISR_C0, PISR_C2, PISR_C3, PISR_C6, PISR_C8, PISR_C10
    } pisr_cstate_t;
    // exit latencies in ns for each deep state
    localparam int EXIT_LAT_C3_NS = 100;
    localparam int EXIT_LAT_C6_NS = 200;
    localparam int EXIT_LAT_C8_NS = 400;
    localparam int EXIT_LAT_C10_NS = 1000;
    localparam logic [LAT_W-1:0] EXIT_LAT_C3 = LAT_W'(EXIT_LAT_C3_NS);
    localparam logic [LAT_W-1:0] EXIT_LAT_C6 = LAT_W'(EXIT_LAT_C6_NS);
    localparam logic [LAT_W-1:0] EXIT_LAT_C8 = LAT_W'(EXIT_LAT_C8_NS);
    localparam logic [LAT_W-1:0] EXIT_LAT_C10 = LAT_W'(EXIT_LAT_C10_NS);
    // wake-rate threshold (wakes per window) above which C8 and C10 are demoted to C6
    localparam logic [WAKE_W-1:0] WAKE_DEMOTE_THRESH = 8'h10;
    // per-step time of a gradual flush or restore of one way
    localparam int WAY_STEP_NS = 40;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAY_STEP_CYC = (WAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WAY_STEP_CYC_M1 = 8'(WAY_STEP_CYC - 1);
    localparam logic [WAY_W-1:0] WAYS_ALL = WAY_W'(LLC_WAYS);
    localparam logic [WAY_W-1:0] WAYS_NONE = 4'h0;
    localparam logic AUTO_DEMOTE_RESET = 1'b1;
endpackage : pisr_pkg

// ===== logic/pisr_resolver.sv
`timescale 1ns/1ps
module pisr_resolver (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // core and graphics idle status
    input wire pisr_pkg::pisr_cstate_t core_cstate [pisr_pkg::NUM_CORES],
    input wire logic [pisr_pkg::NUM_CORES-1:0] flush_all_hint,
    input wire logic graphics_power_down_state,
    input wire logic wake_event,
    // platform status
    input wire logic [pisr_pkg::LAT_W-1:0] latency_tolerance_report,
    input wire logic [pisr_pkg::WAKE_W-1:0] core_wake_rate,
    input wire logic entry_energy_ok,
    input wire logic display_on,
    input wire logic display_count_single,
    input wire logic display_embedded,
    input wire logic panel_self_refresh_capable,
    input wire logic panel_self_refresh_enabled,
    // firmware configuration
    input wire logic auto_demote_cfg,
    input wire logic auto_demote_cfg_load,
    // package state and platform controls
    output pisr_pkg::pisr_cstate_t pkg_cstate,
    output logic base_clk_stop,
    output logic crystal_clk_stop,
    output logic [1:0] regulator_power_state,
    output logic memory_self_refresh_manager,
    output logic llc_power_off,
    output logic [pisr_pkg::WAY_W-1:0] llc_ways_active,
    output logic auto_demote_en
);
    import pisr_pkg::*;

    pisr_cstate_t req_state;
    pisr_cstate_t qual_state;
    pisr_cstate_t target_state;
    pisr_cstate_t pkg_reg;
    logic [WAY_W-1:0] ways_reg;
    logic [7:0] step_cnt_reg;
    logic all_c6;
    logic all_c8;
    logic all_c10;
    logic any_flush_all;
    logic self_refresh_ok;
    logic display_quiet;
    logic demote;
    logic auto_demote_reg;

    // shallowest request over all cores
    always_comb begin
        req_state = PISR_C10;
        for (int i = 0; i < NUM_CORES; i++) begin
            if (core_cstate[i] < req_state) begin
                req_state = core_cstate[i];
            end
        end
    end

    assign all_c6 = (req_state >= PISR_C6);
    assign all_c8 = (req_state >= PISR_C8);
    assign all_c10 = (req_state == PISR_C10);
    assign any_flush_all = |flush_all_hint;

    // self refresh only counts for one embedded panel that supports it
    assign self_refresh_ok = display_count_single && display_embedded
        && panel_self_refresh_capable && panel_self_refresh_enabled;
    assign display_quiet = !display_on || self_refresh_ok;

    // demotion when wakes are frequent or the entry energy is not paid back
    assign demote = auto_demote_reg
        && ((core_wake_rate > WAKE_DEMOTE_THRESH) || !entry_energy_ok);

    // deepest state whose conditions all hold, falling back step by step
    always_comb begin
        qual_state = PISR_C0;
        if (all_c6 && graphics_power_down_state) begin
            qual_state = PISR_C2;
            if (latency_tolerance_report >= EXIT_LAT_C3) begin
                qual_state = PISR_C3;
            end
            if (latency_tolerance_report >= EXIT_LAT_C6) begin
                qual_state = PISR_C6;
            end
            if (all_c8 && latency_tolerance_report >= EXIT_LAT_C8) begin
                qual_state = PISR_C8;
            end
            if (all_c10 && display_quiet && latency_tolerance_report >= EXIT_LAT_C10) begin
                qual_state = PISR_C10;
            end
        end
    end

    always_comb begin
        target_state = qual_state;
        if (demote && qual_state > PISR_C6) begin
            target_state = PISR_C6;
        end
        if (wake_event) begin
            target_state = PISR_C0;
        end
    end

    // firmware switch for auto-demotion, enabled from reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_demote_reg <= AUTO_DEMOTE_RESET;
        end else if (clk_en && auto_demote_cfg_load) begin
            auto_demote_reg <= auto_demote_cfg;
        end
    end

    // package state; C8 and deeper are held back until the cache is drained
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pkg_reg <= PISR_C0;
        end else if (clk_en) begin
            if (target_state >= PISR_C8 && ways_reg != WAYS_NONE) begin
                pkg_reg <= PISR_C6;
            end else begin
                pkg_reg <= target_state;
            end
        end
    end

    // cache sizing: flush on deep request, regrow gradually on return to active
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ways_reg <= WAYS_ALL;
            step_cnt_reg <= 8'h00;
        end else if (clk_en) begin
            if (target_state >= PISR_C8) begin
                if (any_flush_all) begin
                    ways_reg <= WAYS_NONE;
                    step_cnt_reg <= 8'h00;
                end else if (ways_reg != WAYS_NONE) begin
                    if (step_cnt_reg == WAY_STEP_CYC_M1) begin
                        ways_reg <= ways_reg - 4'h1;
                        step_cnt_reg <= 8'h00;
                    end else begin
                        step_cnt_reg <= step_cnt_reg + 8'h01;
                    end
                end
            end else if (pkg_reg == PISR_C0 && ways_reg != WAYS_ALL) begin
                // one way per step keeps the refill traffic from stalling the cores
                if (step_cnt_reg == WAY_STEP_CYC_M1) begin
                    ways_reg <= ways_reg + 4'h1;
                    step_cnt_reg <= 8'h00;
                end else begin
                    step_cnt_reg <= step_cnt_reg + 8'h01;
                end
            end else begin
                step_cnt_reg <= 8'h00;
            end
        end
    end

    // platform controls follow the committed package state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pkg_cstate <= PISR_C0;
            base_clk_stop <= 1'b0;
            crystal_clk_stop <= 1'b0;
            regulator_power_state <= 2'h0;
            memory_self_refresh_manager <= 1'b0;
            llc_power_off <= 1'b0;
            llc_ways_active <= WAYS_ALL;
            auto_demote_en <= AUTO_DEMOTE_RESET;
        end else if (clk_en) begin
            pkg_cstate <= pkg_reg;
            memory_self_refresh_manager <= (pkg_reg >= PISR_C3);
            base_clk_stop <= (pkg_reg >= PISR_C6);
            llc_power_off <= (pkg_reg >= PISR_C8) && (ways_reg == WAYS_NONE);
            crystal_clk_stop <= (pkg_reg == PISR_C10);
            case (pkg_reg)
                PISR_C10: regulator_power_state <= 2'h3;
                PISR_C8: regulator_power_state <= 2'h2;
                PISR_C6: regulator_power_state <= 2'h1;
                default: regulator_power_state <= 2'h0;
            endcase
            llc_ways_active <= ways_reg;
            auto_demote_en <= auto_demote_reg;
        end
    end
endmodule : pisr_resolver

// ===== sim/pisr_platform_model.sv
`timescale 1ns/1ps
module pisr_platform_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // tolerance the platform devices want to report
    input wire logic [pisr_pkg::LAT_W-1:0] tol_set,
    output logic [pisr_pkg::LAT_W-1:0] latency_tolerance_report
);
    // zero out of reset: no deep state may be granted before devices report
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latency_tolerance_report <= 16'h0000;
        end else begin
            latency_tolerance_report <= tol_set;
        end
    end
endmodule : pisr_platform_model

// ===== sim/pisr_assertions.sv
`timescale 1ns/1ps
module pisr_assertions (
    // clock, reset and inputs
    input wire logic clk,
    input wire logic reset_n,
    input wire pisr_pkg::pisr_cstate_t core_cstate [pisr_pkg::NUM_CORES],
    input wire logic graphics_power_down_state,
    input wire logic wake_event,
    input wire logic display_on,
    input wire logic panel_self_refresh_enabled,
    // outputs
    input wire pisr_pkg::pisr_cstate_t pkg_cstate,
    input wire logic base_clk_stop,
    input wire logic crystal_clk_stop,
    input wire logic [1:0] regulator_power_state,
    input wire logic memory_self_refresh_manager,
    input wire logic [pisr_pkg::WAY_W-1:0] llc_ways_active
);
    import pisr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic all_c8;
    logic disp_ok;
    // $past needs plain signals, so the conditions are gathered here
    always_comb begin
        all_c8 = 1'b1;
        foreach (core_cstate[i]) all_c8 &= (core_cstate[i] >= PISR_C8);
    end
    assign disp_ok = !display_on || panel_self_refresh_enabled;
    a_base_clk_c6: assert property (base_clk_stop == (pkg_cstate >= PISR_C6)) else $error("base clock stop wrong");
    a_crystal_c10: assert property (crystal_clk_stop == (pkg_cstate == PISR_C10)) else $error("crystal stop wrong");
    a_mem_sr_c3: assert property (memory_self_refresh_manager == (pkg_cstate >= PISR_C3)) else $error("mem sr wrong");
    a_vr_deepest: assert property (pkg_cstate == PISR_C10 |-> regulator_power_state == 2'h3)
        else $error("regulator not deepest");
    a_c8_cache_off: assert property (pkg_cstate >= PISR_C8 |-> llc_ways_active == 4'h0) else $error("ways live");
    a_c8_cores: assert property (pkg_cstate >= PISR_C8 |-> $past(all_c8, 2)) else $error("deep without cores");
    a_c10_entry: assert property (pkg_cstate == PISR_C10 |-> $past(graphics_power_down_state, 2) && $past(disp_ok, 2))
        else $error("c10 without conditions");
    a_wake_exit: assert property ($rose(wake_event) |-> ##2 pkg_cstate == PISR_C0) else $error("no wake exit");
    a_ways_step: assert property (llc_ways_active > $past(llc_ways_active)
        |-> llc_ways_active == $past(llc_ways_active) + 4'h1) else $error("cache regrow not gradual");
    c_c10: cover property (pkg_cstate == PISR_C10);
    c_c8: cover property (pkg_cstate == PISR_C8);
    c_wake: cover property ($rose(wake_event));
endmodule : pisr_assertions
bind pisr_resolver pisr_assertions chk (.clk, .reset_n, .core_cstate, .graphics_power_down_state, .wake_event,
    .display_on, .panel_self_refresh_enabled, .pkg_cstate, .base_clk_stop, .crystal_clk_stop,
    .regulator_power_state, .memory_self_refresh_manager, .llc_ways_active);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import pisr_pkg::*;
    logic clk = 0, reset_n = 0, gfx = 0, wake = 0, dsp = 0, psr = 0, cfg = 0, ld = 0;
    logic bclk, xclk, msr, loff, ade;
    logic [1:0] vr;
    logic [WAY_W-1:0] ways;
    logic [NUM_CORES-1:0] hint = 4'h0;
    logic [LAT_W-1:0] tol = 16'h0000, lat;
    logic [WAKE_W-1:0] wr = 8'h00;
    pisr_cstate_t cs [NUM_CORES] = '{default: PISR_C0};
    pisr_cstate_t pkg;
    int fail_count = 0, n_tests = 0;
    initial forever #5 clk = ~clk;
    pisr_platform_model plat (.clk(clk), .reset_n(reset_n), .tol_set(tol), .latency_tolerance_report(lat));
    pisr_resolver dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .core_cstate(cs), .flush_all_hint(hint),
        .graphics_power_down_state(gfx), .wake_event(wake), .latency_tolerance_report(lat), .core_wake_rate(wr),
        .entry_energy_ok(1'b1), .display_on(dsp), .display_count_single(1'b1), .display_embedded(1'b1),
        .panel_self_refresh_capable(1'b1), .panel_self_refresh_enabled(psr), .auto_demote_cfg(cfg),
        .auto_demote_cfg_load(ld), .pkg_cstate(pkg), .base_clk_stop(bclk), .crystal_clk_stop(xclk),
        .regulator_power_state(vr), .memory_self_refresh_manager(msr), .llc_power_off(loff),
        .llc_ways_active(ways), .auto_demote_en(ade));
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // bounded wait; a stuck state ends the run rather than hanging it
    task automatic wait_st(pisr_cstate_t e, int lim);
        for (int i = 0; i < lim && pkg !== e; i++) @(negedge clk);
        `CHK("pkg_cstate", e, pkg)
        if (pkg !== e) test_done();
    endtask : wait_st
    task automatic t_c10;
        @(negedge clk);
        `CHK("auto_demote_en", 1'b1, ade)
        cfg = 1'b0;
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        cs = '{default: PISR_C10};
        gfx = 1'b1;
        tol = 16'h03E8;
        hint = 4'hF;
        wait_st(PISR_C10, 20);
        `CHK("crystal", 1'b1, xclk)
        `CHK("regulator", 2'h3, vr)
        `CHK("llc_off", 1'b1, loff)
        `CHK("ways", WAYS_NONE, ways)
        $display("t_c10 done");
    endtask : t_c10
    task automatic t_wake;
        @(negedge clk);
        wake = 1'b1;
        wait_st(PISR_C0, 10);
        `CHK("ways partial", 1'b1, ways < WAYS_ALL)
        for (int i = 0; i < 60 && ways !== WAYS_ALL; i++) @(negedge clk);
        `CHK("ways full", WAYS_ALL, ways)
        if (ways !== WAYS_ALL) test_done();
        $display("t_wake done");
    endtask : t_wake
    task automatic t_display;
        @(negedge clk);
        // wake and the flush hint drop together with the display change so the flush starts gradual
        wake = 1'b0;
        dsp = 1'b1;
        hint = 4'h0;
        repeat (6) @(negedge clk);
        `CHK("ways gradual", 1'b1, ways != WAYS_NONE)
        wait_st(PISR_C8, 80);
        `CHK("regulator", 2'h2, vr)
        psr = 1'b1;
        wait_st(PISR_C10, 20);
        $display("t_display done");
    endtask : t_display
    task automatic t_demote;
        @(negedge clk);
        wr = 8'h11;
        repeat (3) @(negedge clk);
        `CHK("pkg_cstate", PISR_C10, pkg)
        cfg = 1'b1;
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        wait_st(PISR_C6, 20);
        `CHK("auto_demote_en", 1'b1, ade)
        `CHK("base_clk", 1'b1, bclk)
        $display("t_demote done");
    endtask : t_demote
    task automatic t_shallow;
        @(negedge clk);
        wr = 8'h00;
        tol = 16'h0096;
        wait_st(PISR_C3, 20);
        `CHK("mem_sr", 1'b1, msr)
        tol = 16'h0032;
        wait_st(PISR_C2, 20);
        `CHK("mem_sr", 1'b0, msr)
        cs[1] = PISR_C3;
        wait_st(PISR_C0, 20);
        $display("t_shallow done");
    endtask : t_shallow
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        t_c10();
        t_wake();
        t_display();
        t_demote();
        t_shallow();
        test_done();
    end
endmodule : tb_top
